/* File: core/lrlpm_regs.vh */
/*
 Register offsets, field positions and reset values of the LCD pixel mapper.
 Assumes inclusion by the mapper top only; definitions only, no logic.
*/
`ifndef LRLPM_REGS_VH
`define LRLPM_REGS_VH

// Register word indices (byte address bits 4:2)
`define LRLPM_OFS_CTL 3'h0
`define LRLPM_OFS_DIV 3'h1
`define LRLPM_OFS_HTIM 3'h2
`define LRLPM_OFS_VTIM 3'h3
`define LRLPM_OFS_SYNC 3'h4
`define LRLPM_OFS_STATUS 3'h5

// Control fields
`define LRLPM_CTL_EN 0
`define LRLPM_CTL_MODE_LO 1
`define LRLPM_CTL_MODE_HI 3
`define LRLPM_CTL_LVDS_EN 4
`define LRLPM_CTL_LVDS_24 5
`define LRLPM_CTL_DUAL 6
`define LRLPM_CTL_OE_SWAP 7
`define LRLPM_CTL_MIRROR 8
`define LRLPM_CTL_MASK 32'h000001FF

// Writable bits of the other registers
`define LRLPM_DIV_MASK 32'h000000FF
`define LRLPM_TIM_MASK 32'h0FFF0FFF
`define LRLPM_SYNC_MASK 32'h0003FFFF

// Sync polarity fields
`define LRLPM_SYNC_HS_INV 16
`define LRLPM_SYNC_VS_INV 17

// RGB output modes
`define LRLPM_MODE_P24 3'h0
`define LRLPM_MODE_P18 3'h1
`define LRLPM_MODE_P16 3'h2
`define LRLPM_MODE_P8C 3'h3
`define LRLPM_MODE_S24 3'h4
`define LRLPM_MODE_S18 3'h5

// Status fields
`define LRLPM_ST_UNDERRUN 0
`define LRLPM_ST_VBLANK 1

// Reset values
`define LRLPM_RST_CTL 32'h00000000
`define LRLPM_RST_DIV 32'h00000001
`define LRLPM_RST_HTIM 32'h00140010
`define LRLPM_RST_VTIM 32'h000C0008
`define LRLPM_RST_SYNC 32'h00000202

// LVDS clock lane pattern and lane width
`define LRLPM_LVDS_CLK_PAT 7'h63
`define LRLPM_LANE_W 7

`endif

/* File: core/lrlpm_top.v */
/*
 LCD pixel mapper: timing generator, RGB serial/parallel pin mapping and
 LVDS lane arrangement, with an Avalon-MM slave for its control registers.
 Assumes a pixel source with valid/ready handshake on clk_i, a panel that
 samples data on the rising edge of dclk_o, and an external LVDS serializer
 that shifts each 7-bit lane word out per LVDS clock.
*/
`timescale 1ns/1ps
`include "lrlpm_regs.vh"

module lrlpm_top #(
	parameter CNT_W = 12
) (
	input wire clk_i,
	input wire srst_i,
	input wire [5:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire pix_valid_i,
	input wire [23:0] pix_data_i,
	input wire pix_sof_i,
	output reg pix_ready_o,
	output reg dclk_o,
	output reg hsync_o,
	output reg vsync_o,
	output reg pixel_data_valid_o,
	output reg [23:0] lcd_data_o,
	output reg [34:0] lvds_even_pair_o,
	output reg [4:0] lvds_even_en_o,
	output reg [34:0] lvds_odd_pair_o,
	output reg [4:0] lvds_odd_en_o
);

	// Software-visible configuration
	reg [31:0] ctl_reg;
	reg [31:0] div_reg;
	reg [31:0] htim_reg;
	reg [31:0] vtim_reg;
	reg [31:0] sync_reg;
	reg underrun_reg;
	// Timing generator and stream state
	reg [9:0] cnt_reg;
	reg [1:0] phase_reg;
	reg [CNT_W-1:0] hpos_reg;
	reg [CNT_W-1:0] vpos_reg;
	reg [23:0] pix_cur_reg;
	reg [23:0] hold_data_reg;
	reg hold_sof_reg;
	reg hold_full_reg;
	reg pix_odd_reg;
	reg [27:0] ev_buf_reg;
	reg [CNT_W-1:0] h_next;
	reg [CNT_W-1:0] v_next;
	reg [31:0] bus_wmask;

	// Bus decode and control fields
	wire [2:0] reg_idx = avs_address_i[4:2];
	wire bus_req = avs_read_i | avs_write_i;
	wire bus_do = bus_req & ~avs_waitrequest_o;
	wire bus_wr = avs_write_i & ~avs_waitrequest_o;
	wire en = ctl_reg[`LRLPM_CTL_EN];
	wire [2:0] mode = ctl_reg[`LRLPM_CTL_MODE_HI:`LRLPM_CTL_MODE_LO];
	wire lvds_en = ctl_reg[`LRLPM_CTL_LVDS_EN];
	wire lvds_24 = ctl_reg[`LRLPM_CTL_LVDS_24];
	wire dual = ctl_reg[`LRLPM_CTL_DUAL];
	wire oe_swap = ctl_reg[`LRLPM_CTL_OE_SWAP];
	wire mirror = ctl_reg[`LRLPM_CTL_MIRROR];
	// LVDS always uses parallel pixel timing
	wire serial = ~lvds_en & ((mode == `LRLPM_MODE_S24) | (mode == `LRLPM_MODE_S18));
	// Timing fields; bits above CNT_W are ignored
	wire [CNT_W-1:0] hact = htim_reg[CNT_W-1:0];
	wire [CNT_W-1:0] htot = htim_reg[16+CNT_W-1:16];
	wire [CNT_W-1:0] vact = vtim_reg[CNT_W-1:0];
	wire [CNT_W-1:0] vtot = vtim_reg[16+CNT_W-1:16];
	wire [CNT_W-1:0] hsw = {{(CNT_W-8){1'b0}}, sync_reg[7:0]};
	wire [CNT_W-1:0] vsw = {{(CNT_W-8){1'b0}}, sync_reg[15:8]};
	wire hs_pol = sync_reg[`LRLPM_SYNC_HS_INV];
	wire vs_pol = sync_reg[`LRLPM_SYNC_VS_INV];

	// Phase period in clk cycles; zero divider treated as one
	wire [9:0] phase_div = (div_reg[7:0] == 8'h00) ? 10'h001 : {2'h0, div_reg[7:0]};
	wire [9:0] period = serial ? phase_div : phase_div * 10'h003;
	wire tick = en & (cnt_reg >= period - 10'h001);
	wire step = tick & (~serial | (phase_reg == 2'h2));

	// Level for the coming cycle: low from each period start, so data leads the rise
	// A divider of one in serial mode leaves no room for a pulse; dclk then stays low
	wire dclk_next = ~tick & (cnt_reg + 10'h001 >= (period >> 1));

	wire act_next = (h_next < hact) & (v_next < vact);
	wire first_next = (h_next == {CNT_W{1'b0}}) & (v_next == {CNT_W{1'b0}});
	// A held frame start waits for the panel's own frame start
	wire take = step & act_next & hold_full_reg & (~hold_sof_reg | first_next);
	wire [23:0] pix_next = take ? hold_data_reg : 24'h000000;
	wire hs_next = ((h_next >= hact) & (h_next < hact + hsw)) ^ hs_pol;
	wire vs_next = ((v_next >= vact) & (v_next < vact + vsw)) ^ vs_pol;
	wire hold_full_next = (hold_full_reg & ~take) | (pix_valid_i & pix_ready_o);
	wire [27:0] words_next = lane_words(pix_next, act_next, hs_next, vs_next);

	// Line start is always an even pixel, whatever the line length
	wire pix_even = (h_next == {CNT_W{1'b0}}) | ~pix_odd_reg;

	// Status word: current line, vertical blank flag and sticky underrun
	wire [31:0] status_word = {4'h0, vpos_reg, 14'h0000, ~(vpos_reg < vact), underrun_reg};

	// Masked write values; reserved bits always read back as zero
	wire [31:0] ctl_next = ((ctl_reg & ~bus_wmask) | (avs_writedata_i & bus_wmask)) & `LRLPM_CTL_MASK;
	wire [31:0] div_next = ((div_reg & ~bus_wmask) | (avs_writedata_i & bus_wmask)) & `LRLPM_DIV_MASK;
	wire [31:0] htim_next = ((htim_reg & ~bus_wmask) | (avs_writedata_i & bus_wmask)) & `LRLPM_TIM_MASK;
	wire [31:0] vtim_next = ((vtim_reg & ~bus_wmask) | (avs_writedata_i & bus_wmask)) & `LRLPM_TIM_MASK;
	wire [31:0] sync_next = ((sync_reg & ~bus_wmask) | (avs_writedata_i & bus_wmask)) & `LRLPM_SYNC_MASK;

	// Byte-enable mask for register writes
	always @* begin
		bus_wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	end

	// Panel position of the next pixel, wrapping at line and frame ends
	always @* begin
		h_next = hpos_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		v_next = vpos_reg;
		if (hpos_reg >= htot - {{(CNT_W-1){1'b0}}, 1'b1}) begin
			h_next = {CNT_W{1'b0}};
			if (vpos_reg >= vtot - {{(CNT_W-1){1'b0}}, 1'b1}) begin
				v_next = {CNT_W{1'b0}};
			end else begin
				v_next = vpos_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Component for a phase: red, then green, then blue
	function [7:0] comp_sel;
		input [23:0] p;
		input [1:0] ph;
		begin
			case (ph)
				2'h0: comp_sel = p[23:16];
				2'h1: comp_sel = p[15:8];
				default: comp_sel = p[7:0];
			endcase
		end
	endfunction

	// RGB pin mapping; unused lines held low to keep them quiet
	function [23:0] rgb_map;
		input [2:0] m;
		input [23:0] p;
		input [1:0] ph;
		reg [7:0] c;
		begin
			c = comp_sel(p, ph);
			case (m)
				`LRLPM_MODE_P24: rgb_map = p;
				`LRLPM_MODE_P18: rgb_map = p & 24'hFCFCFC;
				`LRLPM_MODE_P16: rgb_map = p & 24'hF8FCF8;
				`LRLPM_MODE_P8C: rgb_map = p & 24'h808080;
				`LRLPM_MODE_S24: rgb_map = {12'h000, c[7:6], 2'h0, c[5:0], 2'h0};
				`LRLPM_MODE_S18: rgb_map = {16'h0000, c[7:2], 2'h0};
				default: rgb_map = 24'h000000;
			endcase
		end
	endfunction

	// Four 7-bit lane words, bit 6 shifted first
	function [27:0] lane_words;
		input [23:0] p;
		input de;
		input hs;
		input vs;
		reg [6:0] l0;
		reg [6:0] l1;
		reg [6:0] l2;
		reg [6:0] l3;
		begin
			l0 = {p[8], p[21:16]};
			l1 = {p[1:0], p[13:9]};
			l2 = {de, vs, hs, p[5:2]};
			l3 = {1'b0, p[7:6], p[15:14], p[23:22]};
			lane_words = {l3, l2, l1, l0};
		end
	endfunction

	// Lane words onto five pin pairs, pair 0 in the low bits
	function [34:0] pin_arrange;
		input [27:0] w;
		input b24;
		input mir;
		reg [6:0] ck;
		begin
			ck = `LRLPM_LVDS_CLK_PAT;
			case ({b24, mir})
				2'b00: pin_arrange = {7'h00, ck, w[20:14], w[13:7], w[6:0]};
				2'b01: pin_arrange = {7'h00, w[6:0], w[13:7], w[20:14], ck};
				2'b10: pin_arrange = {w[27:21], ck, w[20:14], w[13:7], w[6:0]};
				default: pin_arrange = {w[6:0], w[13:7], w[20:14], ck, w[27:21]};
			endcase
		end
	endfunction

	// Avalon slave: one wait cycle, access acts when waitrequest is low
	always @(posedge clk_i) begin
		if (srst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else begin
			avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
			// Read data loads in the wait cycle so it stands once waitrequest drops
			if (avs_read_i & avs_waitrequest_o) begin
				case (reg_idx)
					`LRLPM_OFS_CTL: avs_readdata_o <= ctl_reg;
					`LRLPM_OFS_DIV: avs_readdata_o <= div_reg;
					`LRLPM_OFS_HTIM: avs_readdata_o <= htim_reg;
					`LRLPM_OFS_VTIM: avs_readdata_o <= vtim_reg;
					`LRLPM_OFS_SYNC: avs_readdata_o <= sync_reg;
					`LRLPM_OFS_STATUS: avs_readdata_o <= status_word;
					default: avs_readdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Configuration registers; unmapped writes ignored
	always @(posedge clk_i) begin
		if (srst_i) begin
			ctl_reg <= `LRLPM_RST_CTL;
			div_reg <= `LRLPM_RST_DIV;
			htim_reg <= `LRLPM_RST_HTIM;
			vtim_reg <= `LRLPM_RST_VTIM;
			sync_reg <= `LRLPM_RST_SYNC;
		end else if (bus_wr) begin
			case (reg_idx)
				`LRLPM_OFS_CTL: ctl_reg <= ctl_next;
				`LRLPM_OFS_DIV: div_reg <= div_next;
				`LRLPM_OFS_HTIM: htim_reg <= htim_next;
				`LRLPM_OFS_VTIM: vtim_reg <= vtim_next;
				`LRLPM_OFS_SYNC: sync_reg <= sync_next;
				default: ctl_reg <= ctl_reg;
			endcase
		end
	end

	// Underrun sticky; a new underrun wins over a write-one clear
	always @(posedge clk_i) begin
		if (srst_i) begin
			underrun_reg <= 1'b0;
		end else if (step & act_next & ~take) begin
			underrun_reg <= 1'b1;
		end else if (bus_wr & (reg_idx == `LRLPM_OFS_STATUS) & avs_byteenable_i[0]
			& avs_writedata_i[`LRLPM_ST_UNDERRUN]) begin
			underrun_reg <= 1'b0;
		end
	end

	// One-pixel holding stage; ready falls while it is full
	always @(posedge clk_i) begin
		if (srst_i) begin
			hold_full_reg <= 1'b0;
			hold_data_reg <= 24'h000000;
			hold_sof_reg <= 1'b0;
			pix_ready_o <= 1'b0;
		end else begin
			hold_full_reg <= hold_full_next;
			pix_ready_o <= en & ~hold_full_next;
			if (pix_valid_i & pix_ready_o) begin
				hold_data_reg <= pix_data_i;
				hold_sof_reg <= pix_sof_i;
			end
		end
	end

	// Pixel clock divider; dclk low in first half so data settles before rise
	always @(posedge clk_i) begin
		if (srst_i | ~en) begin
			cnt_reg <= 10'h000;
			dclk_o <= 1'b0;
		end else begin
			cnt_reg <= tick ? 10'h000 : cnt_reg + 10'h001;
			dclk_o <= dclk_next;
		end
	end

	// Timing generator and RGB pins; while disabled the position parks so the
	// first pixel after enable lands on the frame origin
	always @(posedge clk_i) begin
		if (srst_i | ~en) begin
			phase_reg <= 2'h0;
			hpos_reg <= {CNT_W{1'b1}};
			vpos_reg <= {CNT_W{1'b1}};
			pix_cur_reg <= 24'h000000;
			hsync_o <= 1'b0;
			vsync_o <= 1'b0;
			pixel_data_valid_o <= 1'b0;
			lcd_data_o <= 24'h000000;
		end else if (step) begin
			phase_reg <= 2'h0;
			hpos_reg <= h_next;
			vpos_reg <= v_next;
			pix_cur_reg <= pix_next;
			hsync_o <= hs_next;
			vsync_o <= vs_next;
			pixel_data_valid_o <= act_next;
			lcd_data_o <= lvds_en ? 24'h000000 : rgb_map(mode, pix_next, 2'h0);
		end else if (tick) begin
			phase_reg <= phase_reg + 2'h1;
			lcd_data_o <= rgb_map(mode, pix_cur_reg, phase_reg + 2'h1);
		end
	end

	// LVDS lane words: single channel uses the even group only, dual pairs
	// an even pixel with the following odd one on one LVDS clock
	always @(posedge clk_i) begin
		if (srst_i | ~en | ~lvds_en) begin
			pix_odd_reg <= 1'b0;
			ev_buf_reg <= 28'h0000000;
			lvds_even_pair_o <= 35'h000000000;
			lvds_odd_pair_o <= 35'h000000000;
			lvds_even_en_o <= 5'h00;
			lvds_odd_en_o <= 5'h00;
		end else if (step) begin
			pix_odd_reg <= (h_next == {CNT_W{1'b0}}) ? 1'b1 : ~pix_odd_reg;
			lvds_even_en_o <= lvds_24 ? 5'h1F : 5'h0F;
			lvds_odd_en_o <= (dual & lvds_24) ? 5'h1F : (dual ? 5'h0F : 5'h00);
			if (~dual) begin
				lvds_even_pair_o <= pin_arrange(words_next, lvds_24, mirror);
				lvds_odd_pair_o <= 35'h000000000;
			end else if (pix_even) begin
				ev_buf_reg <= words_next;
			end else if (oe_swap) begin
				lvds_even_pair_o <= pin_arrange(words_next, lvds_24, mirror);
				lvds_odd_pair_o <= pin_arrange(ev_buf_reg, lvds_24, mirror);
			end else begin
				lvds_even_pair_o <= pin_arrange(ev_buf_reg, lvds_24, mirror);
				lvds_odd_pair_o <= pin_arrange(words_next, lvds_24, mirror);
			end
		end
	end

endmodule

/* File: tb/lrlpm_top_assertions.sv */
/*
 Checker on the pixel mapper top ports: bus handshake, stream hold, sync alignment, LVDS lanes.
 Assumes a single clk_i domain and a bind to every lrlpm_top instance.
*/
`timescale 1ns/1ps
module lrlpm_checker (
	input wire clk_i,
	input wire srst_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire avs_waitrequest_o,
	input wire pix_valid_i,
	input wire pix_ready_o,
	input wire dclk_o,
	input wire hsync_o,
	input wire vsync_o,
	input wire pixel_data_valid_o,
	input wire [23:0] lcd_data_o,
	input wire [34:0] lvds_even_pair_o,
	input wire [4:0] lvds_even_en_o,
	input wire [4:0] lvds_odd_en_o
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// Bus answers one cycle after a request, never holds the master longer
	bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus request not answered next cycle");
	bus_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	// One-entry hold: a taken pixel closes the door until consumed
	stream_hold_a: assert property (pix_valid_i && pix_ready_o |=> !pix_ready_o)
		else $error("ready stayed high after a take");
	// Strobes move only in the low half, so the panel never samples a half-changed pixel
	sync_align_a: assert property ($changed(pixel_data_valid_o) || $changed(hsync_o) || $changed(vsync_o) |-> !dclk_o)
		else $error("strobe changed while pixel clock high");
	clock_runs_a: assert property ($rose(pixel_data_valid_o) |-> ##[1:800] $rose(dclk_o))
		else $error("no pixel clock edge after data valid");
	lane_count_a: assert property (lvds_even_en_o inside {5'h00, 5'h0F, 5'h1F})
		else $error("even group drives an odd set of pairs");
	odd_group_a: assert property (lvds_odd_en_o != 5'h00 |-> lvds_odd_en_o == lvds_even_en_o)
		else $error("odd group differs from even group");
	clk_lane24_a: assert property (lvds_even_en_o == 5'h1F |->
		lvds_even_pair_o[27:21] == 7'h63 || lvds_even_pair_o[13:7] == 7'h63)
		else $error("clock lane missing in wide mode");
	clk_lane18_a: assert property (lvds_even_en_o == 5'h0F |->
		lvds_even_pair_o[27:21] == 7'h63 || lvds_even_pair_o[6:0] == 7'h63)
		else $error("clock lane missing in narrow mode");
	rgb_quiet_a: assert property (lvds_even_en_o != 5'h00 |-> lcd_data_o == 24'h0)
		else $error("RGB lines active while LVDS drives");
endmodule

bind lrlpm_top lrlpm_checker i_lrlpm_checker (.clk_i(clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .pix_valid_i(pix_valid_i),
	.pix_ready_o(pix_ready_o), .dclk_o(dclk_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
	.pixel_data_valid_o(pixel_data_valid_o), .lcd_data_o(lcd_data_o), .lvds_even_pair_o(lvds_even_pair_o),
	.lvds_even_en_o(lvds_even_en_o), .lvds_odd_en_o(lvds_odd_en_o));

/* File: tb/lrlpm_panel_model.sv */
/*
 Panel model: samples data on each rising pixel clock while data valid is high.
 Assumes the pixel clock is slow enough to be seen by clk_i; keeps one word per colour phase.
*/
`timescale 1ns/1ps
module lrlpm_panel_model (
	input wire logic clk_i,
	input wire logic dclk_i,
	input wire logic de_i,
	input wire logic [23:0] data_i,
	input wire logic [34:0] lv_i,
	output logic [71:0] cap_o,
	output logic [34:0] lv_o,
	output int per_o
);
	logic dclk_q = 1'b0;
	logic de_q = 1'b0;
	logic [1:0] ph = 2'h0;
	int n = 0;

	// Phase restarts at each line start, as a real serial panel would
	always @(posedge clk_i) begin
		logic [1:0] p;
		dclk_q <= dclk_i;
		n <= n + 1;
		if (dclk_i && !dclk_q) begin
			per_o <= n;
			n <= 1;
			de_q <= de_i;
			if (de_i) begin
				p = de_q ? ((ph == 2'h2) ? 2'h0 : ph + 2'h1) : 2'h0;
				ph <= p;
				cap_o[p * 24 +: 24] <= data_i;
				lv_o <= lv_i;
			end
		end
	end
endmodule

/* File: tb/tb_top.sv */
/*
 Bench for the pixel mapper: register table, every RGB mode, 18/24-bit single and 24-bit dual LVDS, mid-run reset.
 Assumes the panel model and checker bind are compiled before it; source always valid.
*/
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic [31:0] ctl; logic [71:0] px; int per; logic [4:0] ee, oe; logic [34:0] lw;} lrlpm_row_t;
	logic clk_i, srst_i, avs_read_i, avs_write_i, pix_valid_i, pix_sof_i;
	logic [5:0] avs_address_i;
	logic [31:0] avs_writedata_i, q;
	logic [3:0] avs_byteenable_i;
	logic [23:0] pix_data_i;
	wire [31:0] avs_readdata_o;
	wire avs_waitrequest_o, pix_ready_o, dclk_o, hsync_o, vsync_o, pixel_data_valid_o;
	wire [23:0] lcd_data_o;
	wire [34:0] lvds_even_pair_o, lvds_odd_pair_o, lv;
	wire [4:0] lvds_even_en_o, lvds_odd_en_o;
	wire [71:0] cap;
	int per, num_errors = 0, checks = 0, cyc = 0;
	lrlpm_row_t rows [9];
	logic [37:0] rtab [6] = '{{6'h00, 32'h0}, {6'h04, 32'h1}, {6'h08, 32'h00140010},
		{6'h0C, 32'h000C0008}, {6'h10, 32'h202}, {6'h18, 32'h0}};

	lrlpm_top i_lrlpm_top (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i),
		.pix_sof_i(pix_sof_i), .pix_ready_o(pix_ready_o), .dclk_o(dclk_o), .hsync_o(hsync_o),
		.vsync_o(vsync_o), .pixel_data_valid_o(pixel_data_valid_o), .lcd_data_o(lcd_data_o),
		.lvds_even_pair_o(lvds_even_pair_o), .lvds_even_en_o(lvds_even_en_o),
		.lvds_odd_pair_o(lvds_odd_pair_o), .lvds_odd_en_o(lvds_odd_en_o));
	lrlpm_panel_model i_lrlpm_panel_model (.clk_i(clk_i), .dclk_i(dclk_o), .de_i(pixel_data_valid_o),
		.data_i(lcd_data_o), .lv_i(lvds_even_pair_o), .cap_o(cap), .lv_o(lv), .per_o(per));

	// 40 MHz system clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Hang guard, well above the roughly 28000 cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			summarize();
		end
	end

	task summarize;
		if (num_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task chk(input logic [71:0] g, input logic [71:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Request held until waitrequest is sampled low; only the hang guard ends the wait
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
		r = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task rdtab;
		foreach (rtab[i]) begin
			bus(1'b0, rtab[i][37:32], 32'h0, q);
			chk(q, rtab[i][31:0]);
		end
	endtask

	initial begin
		// Constant colour R=A5 G=C3 B=3C, so any sampled pixel has a known mapping
		rows = '{'{32'h01, {3{24'hA5C33C}}, 6, 5'h00, 5'h00, 35'h0},
			'{32'h03, {3{24'hA4C03C}}, 6, 5'h00, 5'h00, 35'h0},
			'{32'h05, {3{24'hA0C038}}, 6, 5'h00, 5'h00, 35'h0},
			'{32'h07, {3{24'h808000}}, 6, 5'h00, 5'h00, 35'h0},
			'{32'h09, {24'h0000F0, 24'h000C0C, 24'h000894}, 2, 5'h00, 5'h00, 35'h0},
			'{32'h0B, {24'h00003C, 24'h0000C0, 24'h0000A4}, 2, 5'h00, 5'h00, 35'h0},
			'{32'h31, 72'h0, 6, 5'h1F, 5'h00, {7'h0E, 7'h63, 7'h4F, 7'h01, 7'h65}},
			'{32'h11, 72'h0, 6, 5'h0F, 5'h00, {7'h00, 7'h63, 7'h4F, 7'h01, 7'h65}},
			'{32'h1F1, 72'h0, 6, 5'h1F, 5'h1F, {7'h65, 7'h01, 7'h4F, 7'h63, 7'h0E}}};
		srst_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 6'h00;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hF;
		pix_valid_i = 1'b1;
		pix_sof_i = 1'b0;
		pix_data_i = 24'hA5C33C;
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b1, 6'h18, 32'hFFFFFFFF, q);
		rdtab();
		bus(1'b1, 6'h04, 32'h2, q);
		// Each mode gets two full frames before its pins are judged
		foreach (rows[i]) begin
			bus(1'b1, 6'h00, rows[i].ctl, q);
			repeat (3000) @(posedge clk_i);
			// Judge right after an active area, so the last samples are whole pixels
			@(posedge hsync_o);
			@(posedge clk_i);
			chk(cap, rows[i].px);
			chk(per, rows[i].per);
			chk(lvds_even_en_o, rows[i].ee);
			chk(lvds_odd_en_o, rows[i].oe);
			chk(lvds_odd_pair_o, (rows[i].oe != 5'h00) ? rows[i].lw : 35'h0);
			chk(lv & {{7{rows[i].ee[4]}}, {7{rows[i].ee[3]}}, {7{rows[i].ee[2]}}, {7{rows[i].ee[1]}},
				{7{rows[i].ee[0]}}}, rows[i].lw);
		end
		// Reset in the middle of dual-channel traffic
		srst_i <= 1'b1;
		@(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk({avs_waitrequest_o, pixel_data_valid_o, pix_ready_o, lvds_even_en_o, lcd_data_o}, {1'b1, 31'h0});
		rdtab();
		summarize();
	end
endmodule
